/* rtl/gyro_fault_id_map.svh */
// register addresses, field positions, reset values and timing figures of the fault/id bank
`ifndef GYRO_FAULT_ID_MAP_SVH
`define GYRO_FAULT_ID_MAP_SVH

// ==========================================================================
// register addresses (byte addresses on the serial link)
`define ADDR_FAULT_FLAGS_HIGH   8'h0A
`define ADDR_FAULT_FLAGS_LOW    8'h0B
`define ADDR_VERSION_CODE_HIGH  8'h0C
`define ADDR_VERSION_CODE_LOW   8'h0D
`define ADDR_UNIT_NUMBER_BYTE3  8'h0E
`define ADDR_UNIT_NUMBER_BYTE2  8'h0F
`define ADDR_UNIT_NUMBER_BYTE1  8'h10
`define ADDR_UNIT_NUMBER_BYTE0  8'h11
`define ADDR_STEP               8'h01

// ==========================================================================
// field layout of the 16-bit fault word
`define FAULT_COND_WIDTH        11
`define FAULT_COND_MSB          11
`define FAULT_COND_LSB          1
`define FAULT_WORD_RESET        16'h0000
`define FAULT_CLEARED           11'h000
`define UNUSED_NIBBLE           4'h0
`define FAULT_BIT0_VALUE        1'b0
`define BYTE_ZERO               8'h00
`define WORD_ZERO               16'h0000

// ==========================================================================
// byte lanes of the 16-bit words and of the 32-bit unit number
`define WORD_HIGH_BYTE          15:8
`define WORD_LOW_BYTE           7:0
`define UNIT_BYTE3_BITS         31:24
`define UNIT_BYTE2_BITS         23:16
`define UNIT_BYTE1_BITS         15:8
`define UNIT_BYTE0_BITS         7:0

// ==========================================================================
// identity values (arbitrary neutral defaults)
`define VERSION_CODE_DEFAULT    16'h0A01

// ==========================================================================
// timing: flag must be visible within this time of its condition
`define SYS_CLK_PERIOD_NS       4
`define FAULT_SET_TIME_NS       5000
`define FAULT_SET_MAX_CYCLES    (`FAULT_SET_TIME_NS / `SYS_CLK_PERIOD_NS)

`endif

/* rtl/gyro_fault_id_pkg.sv */
// types shared by the fault and identification register bank
package gyro_fault_id_pkg;

    // ======================================================================
    // kind of request arriving from the serial link
    typedef enum logic [0:0]
    {
        REQ_MEM_READ    = 1'b0,
        REQ_SENSOR_DATA = 1'b1
    } req_kind_t;

    // ======================================================================
    // link-side handshake state
    typedef enum logic [0:0]
    {
        LINK_IDLE = 1'b0,
        LINK_WAIT = 1'b1
    } link_state_t;

    // request as decoded by the frame logic
    typedef struct packed
    {
        req_kind_t   kind;
        logic [7:0]  addr;
    } link_req_t;

    // answer: 16-bit data field plus the appended low fault byte
    typedef struct packed
    {
        logic [15:0] data;
        logic [7:0]  tail;
    } link_ans_t;

    // 16-bit fault word, bit 15 first
    typedef struct packed
    {
        logic [3:0]  unused;
        logic        overall_fail_flag;
        logic        amplitude_flag;
        logic        overvoltage_flag;
        logic        undervoltage_flag;
        logic        loop_lock_flag;
        logic        quadrature_flag;
        logic        memory_error_flag;
        logic        power_on_reset_flag;
        logic        power_flag;
        logic        continuous_self_test_flag;
        logic        check_flag;
        logic        zero;
    } fault_word_t;

endpackage

/* rtl/bit_sync.sv */
// two-flop synchroniser for levels entering a clock domain
`timescale 1ns/1ns

module bit_sync
#(
    parameter int WIDTH = 1
)
(
    // destination clock
    input  wire logic             i_clk,
    // asynchronous levels
    input  wire logic [WIDTH-1:0] i_async,
    // synchronised levels
    output logic      [WIDTH-1:0] o_sync
);

    // first stage is read only by the second stage
    logic [WIDTH-1:0] meta;

    // ======================================================================
    // two stages, no reset so the chain settles on its own
    always_ff @(posedge i_clk)
    begin
        meta   <= i_async;
        o_sync <= meta;
    end

endmodule

/* rtl/gyro_fault_and_id_registers.sv */
// fault flags, version code and unit number reachable over the serial link
`timescale 1ns/1ns
`include "gyro_fault_id_map.svh"

module gyro_fault_and_id_registers
#(
    // identifies the silicon revision; value is arbitrary
    parameter logic [15:0] VERSION_CODE = `VERSION_CODE_DEFAULT
)
(
    // core clock and reset
    input  wire logic                         i_sys_clk,
    input  wire logic                         i_reset_n,
    // core-side sources
    input  wire logic [`FAULT_COND_WIDTH-1:0] i_fault_cond,
    input  wire logic [15:0]                  i_sensor_word,
    input  wire logic [31:0]                  i_unit_number,
    // link side, clocked by the link clock
    input  wire logic                         i_link_clk,
    input  wire logic                         i_req_valid,
    input  wire gyro_fault_id_pkg::link_req_t i_req,
    output logic                              o_busy,
    output logic                              o_ans_valid,
    output gyro_fault_id_pkg::link_ans_t      o_ans,
    // core-side view of the sticky flags
    output gyro_fault_id_pkg::fault_word_t    o_fault_word
);
    import gyro_fault_id_pkg::*;

    // ======================================================================
    // structure of the bank
    // the link side takes one request at a time and flips a request toggle;
    // the core side sees that toggle two flops later, builds the answer from
    // registers that sit still and flips its own answer toggle back.
    // only single-bit toggles cross between the clocks: the request word and
    // the answer word are written on the same edge as their toggle moves and are
    // not touched again until the other side has consumed them, so neither
    // word is ever sampled while it changes.
    // trade-off: a round trip costs about three link cycles, which is far
    // shorter than one serial frame, so no faster crossing was worth its area.

    // ======================================================================
    // synchronised inputs
    logic [`FAULT_COND_WIDTH-1:0] fault_cond_sync;  // conditions on core clock
    logic                         link_reset_n;     // core reset seen on link clock
    logic                         req_tgl_sync;     // request toggle on core clock
    logic                         ack_tgl_sync;     // answer toggle on link clock

    // ======================================================================
    // link-domain state
    // everything here runs on i_link_clk and is reset by link_reset_n
    link_state_t link_state;       // idle or waiting for an answer
    link_state_t next_link_state;
    link_req_t   req_hold;         // request held stable across the crossing
    link_req_t   next_req_hold;
    logic        req_tgl;          // flips once per accepted request
    logic        next_req_tgl;
    logic        ack_seen;         // last answer toggle consumed
    logic        next_ack_seen;
    logic        next_busy;
    logic        next_ans_valid;
    link_ans_t   next_ans;

    // ======================================================================
    // core-domain state
    // everything here runs on i_sys_clk and is reset by i_reset_n
    fault_word_t flags;            // sticky fault word
    fault_word_t next_flags;
    link_ans_t   ans_hold;         // answer held stable across the crossing
    link_ans_t   next_ans_hold;
    logic        ack_tgl;          // flips once per finished answer
    logic        next_ack_tgl;
    logic        req_seen;         // last request toggle consumed
    logic        next_req_seen;
    logic        req_new;          // a fresh request is waiting
    logic        clear_flags;      // this request clears the sticky flags

    // ======================================================================
    // crossings: fault pins, reset and both toggles
    // fault levels come from analog monitors with no relation to this clock;
    // a condition shorter than one core cycle may slip between samples, which
    // is harmless because the monitors hold a fault far longer than that
    // fault pins pass two flops; 3 core cycles total, far below the 5 us bound
    bit_sync #(.WIDTH(`FAULT_COND_WIDTH)) u_fault_sync
    (
        .i_clk   (i_sys_clk),
        .i_async (i_fault_cond),
        .o_sync  (fault_cond_sync)
    );

    // core reset brought into the link domain
    // the link side leaves reset two link edges after the core side, so the
    // host has to wait a few link cycles after release before its first request
    bit_sync #(.WIDTH(1)) u_reset_sync
    (
        .i_clk   (i_link_clk),
        .i_async (i_reset_n),
        .o_sync  (link_reset_n)
    );

    // request toggle into the core domain
    bit_sync #(.WIDTH(1)) u_req_sync
    (
        .i_clk   (i_sys_clk),
        .i_async (req_tgl),
        .o_sync  (req_tgl_sync)
    );

    // answer toggle back into the link domain
    bit_sync #(.WIDTH(1)) u_ack_sync
    (
        .i_clk   (i_link_clk),
        .i_async (ack_tgl),
        .o_sync  (ack_tgl_sync)
    );

    // ======================================================================
    // byte lookup over the register map
    // the following byte of a pair is addr + 1, wrapping at the top of the
    // byte range; the odd addresses 0x0B and 0x0D straddle two registers, which the host is
    // expected to avoid by naming only the first byte of a pair
    function automatic logic [7:0] read_byte
    (
        input logic [7:0]  addr,
        input fault_word_t fw,
        input logic [31:0] unit
    );
        logic [7:0] b;
        b = `BYTE_ZERO;
        case (addr)
            `ADDR_FAULT_FLAGS_HIGH:  b = fw[`WORD_HIGH_BYTE];
            `ADDR_FAULT_FLAGS_LOW:   b = fw[`WORD_LOW_BYTE];
            `ADDR_VERSION_CODE_HIGH: b = VERSION_CODE[`WORD_HIGH_BYTE];
            `ADDR_VERSION_CODE_LOW:  b = VERSION_CODE[`WORD_LOW_BYTE];
            `ADDR_UNIT_NUMBER_BYTE3: b = unit[`UNIT_BYTE3_BITS];
            `ADDR_UNIT_NUMBER_BYTE2: b = unit[`UNIT_BYTE2_BITS];
            `ADDR_UNIT_NUMBER_BYTE1: b = unit[`UNIT_BYTE1_BITS];
            `ADDR_UNIT_NUMBER_BYTE0: b = unit[`UNIT_BYTE0_BITS];
            // registers outside this bank read as zero here
            default:                 b = `BYTE_ZERO;
        endcase
        return b;
    endfunction

    // ======================================================================
    // link domain: accept a request, wait for the answer
    // only one request is outstanding: a request offered while busy is
    // dropped without notice, so the host must watch o_busy before it asks
    always_comb
    begin
        next_link_state = link_state;
        next_req_hold   = req_hold;
        next_req_tgl    = req_tgl;
        next_ack_seen   = ack_seen;
        next_busy       = o_busy;
        next_ans_valid  = 1'b0;
        next_ans        = o_ans;
        case (link_state)
            LINK_IDLE:
            begin
                // requests are taken only while idle
                if (i_req_valid)
                begin
                    next_req_hold   = i_req;
                    next_req_tgl    = ~req_tgl;
                    next_busy       = 1'b1;
                    next_link_state = LINK_WAIT;
                end
            end
            LINK_WAIT:
            begin
                // answer word is stable once its toggle arrives
                // the toggle went through two flops, so ans_hold settled long before
                if (ack_tgl_sync != ack_seen)
                begin
                    next_ack_seen   = ack_tgl_sync;
                    next_ans        = ans_hold;
                    next_ans_valid  = 1'b1;
                    next_busy       = 1'b0;
                    next_link_state = LINK_IDLE;
                end
            end
            default:
            begin
                next_link_state = LINK_IDLE;
            end
        endcase
    end

    // register the link-domain state
    // reset is the synchronised copy, so it rises and falls cleanly on this
    // clock and never releases half of the state one edge before the rest
    always_ff @(posedge i_link_clk)
    begin
        if (!link_reset_n)
        begin
            link_state  <= LINK_IDLE;
            req_hold    <= '0;
            req_tgl     <= 1'b0;
            ack_seen    <= 1'b0;
            o_busy      <= 1'b0;
            o_ans_valid <= 1'b0;
            o_ans       <= '0;
        end
        else
        begin
            link_state  <= next_link_state;
            req_hold    <= next_req_hold;
            req_tgl     <= next_req_tgl;
            ack_seen    <= next_ack_seen;
            o_busy      <= next_busy;
            o_ans_valid <= next_ans_valid;
            o_ans       <= next_ans;
        end
    end

    // ======================================================================
    // core domain: serve the request and keep the sticky flags
    assign req_new     = (req_tgl_sync != req_seen);
    // a data command or a read at either fault address clears the whole word;
    // reads of the version or unit bytes leave the flags alone
    // either fault byte address counts as reading the fault register
    assign clear_flags = req_new &&
                         ((req_hold.kind == REQ_SENSOR_DATA) ||
                          (req_hold.addr == `ADDR_FAULT_FLAGS_HIGH) ||
                          (req_hold.addr == `ADDR_FAULT_FLAGS_LOW));

    // clear and set are resolved in one cycle: the clear is applied first and
    // a condition still present ORs its flag straight back, so a live fault
    // never shows a gap in the word; the price is that a flag whose cause
    // persists cannot be seen to clear at all, which is what the host wants
    // to learn anyway
    always_comb
    begin
        next_req_seen = req_tgl_sync;
        next_ack_tgl  = ack_tgl;
        next_ans_hold = ans_hold;
        next_flags    = flags;
        // flags hold until cleared; only a serviced fault read or data command clears
        if (clear_flags)
        begin
            next_flags[`FAULT_COND_MSB:`FAULT_COND_LSB] = `FAULT_CLEARED;
        end
        // a live condition sets its flag and wins over the clear
        next_flags[`FAULT_COND_MSB:`FAULT_COND_LSB] =
            next_flags[`FAULT_COND_MSB:`FAULT_COND_LSB] | fault_cond_sync;
        next_flags.unused = `UNUSED_NIBBLE;
        next_flags.zero   = `FAULT_BIT0_VALUE;
        if (req_new)
        begin
            // the answer shows the flags as they stood before the clear
            if (req_hold.kind == REQ_SENSOR_DATA)
            begin
                next_ans_hold.data = i_sensor_word;
            end
            else
            begin
                // addressed byte high, following byte low
                next_ans_hold.data = {read_byte(req_hold.addr, flags, i_unit_number),
                                      read_byte(8'(req_hold.addr + `ADDR_STEP), flags,
                                                i_unit_number)};
            end
            // low fault byte rides along on every answer
            next_ans_hold.tail = flags[`WORD_LOW_BYTE];
            next_ack_tgl       = ~ack_tgl;
        end
    end

    // register the core-domain state
    // o_fault_word takes the same next value as flags, so the core view and
    // the word a read returns never drift apart by a cycle
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            flags        <= `FAULT_WORD_RESET;
            ans_hold     <= '0;
            ack_tgl      <= 1'b0;
            req_seen     <= 1'b0;
            o_fault_word <= `FAULT_WORD_RESET;
        end
        else
        begin
            flags        <= next_flags;
            ans_hold     <= next_ans_hold;
            ack_tgl      <= next_ack_tgl;
            req_seen     <= next_req_seen;
            o_fault_word <= next_flags;
        end
    end

endmodule

/* test/gyro_fault_and_id_registers_chk.sv */
// port-level checks of the fault and identification register bank
`timescale 1ns/1ns
`include "gyro_fault_id_map.svh"

module gyro_fault_and_id_registers_chk
    import gyro_fault_id_pkg::*;
(
    // core domain
    input  wire logic                           i_sys_clk,
    input  wire logic                           i_reset_n,
    input  wire logic [`FAULT_COND_WIDTH-1:0]   i_fault_cond,
    input  wire gyro_fault_id_pkg::fault_word_t o_fault_word,
    // link domain
    input  wire logic                           i_link_clk,
    input  wire logic                           i_req_valid,
    input  wire logic                           o_busy,
    input  wire logic                           o_ans_valid,
    input  wire gyro_fault_id_pkg::link_ans_t   o_ans
);
    // ======================================================================
    // core domain: sticky flags
    // a condition held five cycles must show in the word by the next edge
    for (genvar k = 0; k < `FAULT_COND_WIDTH; k++)
    begin : g_flag
        chk_flag_held : assert property (@(posedge i_sys_clk)
            disable iff (!i_reset_n) i_fault_cond[k] [*5] |=> o_fault_word[k + 1])
            else $error("fault flag not set by a held condition");
    end

    // a flag may only fall while a request is being serviced
    chk_clear_cause : assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        ($past(o_fault_word[11:1]) & ~o_fault_word[11:1]) != 11'h000 |-> o_busy)
        else $error("fault flag fell with no request pending");

    // unused nibble and bit 0 never set
    chk_fixed_bits : assert property (@(posedge i_sys_clk)
        disable iff (!i_reset_n)
        o_fault_word.unused == `UNUSED_NIBBLE && o_fault_word.zero == `FAULT_BIT0_VALUE)
        else $error("reserved fault word bits set");

    // ======================================================================
    // link domain: request and answer
    sequence s_take;
        i_req_valid && !o_busy;
    endsequence
    // busy stands three edges, then the answer pulse ends it
    sequence s_served;
        o_busy [*3] ##[1:3] (o_ans_valid && !o_busy);
    endsequence

    chk_req_served : assert property (@(posedge i_link_clk) disable iff (!i_reset_n)
        s_take |=> s_served)
        else $error("request not answered in time");
    chk_ans_pulse : assert property (@(posedge i_link_clk) disable iff (!i_reset_n)
        o_ans_valid |=> !o_ans_valid && !o_busy)
        else $error("answer pulse longer than one cycle");
    chk_ans_stands : assert property (@(posedge i_link_clk) disable iff (!i_reset_n)
        !o_ans_valid |-> $stable(o_ans))
        else $error("answer changed between answers");
    chk_tail_bit0 : assert property (@(posedge i_link_clk)
        disable iff (!i_reset_n)
        o_ans_valid |-> o_ans.tail[0] == `FAULT_BIT0_VALUE)
        else $error("appended fault byte has bit 0 set");
    chk_ans_cause : assert property (@(posedge i_link_clk) disable iff (!i_reset_n)
        o_ans_valid |-> $past(o_busy))
        else $error("answer without a pending request");
endmodule

bind gyro_fault_and_id_registers gyro_fault_and_id_registers_chk u_chk
(
    .i_sys_clk, .i_reset_n, .i_fault_cond, .o_fault_word,
    .i_link_clk, .i_req_valid, .o_busy, .o_ans_valid, .o_ans
);

/* test/gyro_link_host.sv */
// host model: one link request at a time, collects the answer
`timescale 1ns/1ns

module gyro_link_host
    import gyro_fault_id_pkg::*;
(
    // link clock and answer side
    input  wire logic                         i_link_clk,
    input  wire logic                         i_busy,
    input  wire logic                         i_ans_valid,
    input  wire gyro_fault_id_pkg::link_ans_t i_ans,
    // request side
    output logic                              o_req_valid,
    output gyro_fault_id_pkg::link_req_t      o_req
);
    initial
    begin
        o_req_valid = 1'b0;
        o_req       = '0;
    end

    // ======================================================================
    // issue a request, wait a bounded time for its answer
    task automatic do_req(input req_kind_t kind, input logic [7:0] addr,
                          output link_ans_t ans, output logic ok);
        int n;
        @(posedge i_link_clk);
        for (n = 0; n < 20 && i_busy; n++)
            @(posedge i_link_clk);
        // callers give the first byte of a pair, apart from one read at 0x0B
        o_req_valid <= 1'b1;
        o_req       <= {kind, addr};
        @(posedge i_link_clk);
        // released lines show the inverse so stale values cannot match
        o_req_valid <= 1'b0;
        o_req       <= ~o_req;
        for (n = 0; n < 20 && !i_ans_valid; n++)
            @(posedge i_link_clk);
        ok  = i_ans_valid;
        ans = i_ans;
    endtask
endmodule

/* test/gyro_fault_and_id_registers_tb_top.sv */
// testbench of the fault and identification register bank
`timescale 1ns/1ns

module gyro_fault_and_id_registers_tb_top;
    import gyro_fault_id_pkg::*;
    // revision code, value is arbitrary
    localparam logic [15:0] VERSION = 16'h0A01;
    localparam logic [31:0] UNIT    = 32'hC3A5_5A3C;
    localparam logic [15:0] SENSOR  = 16'h1234;

    logic        sys_clk    = 1'b0;
    logic        link_clk   = 1'b0;
    logic        reset_n    = 1'b0;
    logic [10:0] fault_cond = 11'h000;
    logic        req_valid;
    link_req_t   req;
    logic        busy;
    logic        ans_valid;
    link_ans_t   ans;
    fault_word_t fault_word;
    int          mismatches = 0;
    int          n_tests    = 0;

    // ======================================================================
    // clocks: link edges never coincide with core rising edges
    always #2 sys_clk = ~sys_clk;
    always #40 link_clk = ~link_clk;

    gyro_fault_and_id_registers #(.VERSION_CODE(VERSION)) DUT
    (
        .i_sys_clk(sys_clk), .i_reset_n(reset_n), .i_fault_cond(fault_cond),
        .i_sensor_word(SENSOR), .i_unit_number(UNIT), .i_link_clk(link_clk),
        .i_req_valid(req_valid), .i_req(req), .o_busy(busy),
        .o_ans_valid(ans_valid), .o_ans(ans), .o_fault_word(fault_word)
    );

    gyro_link_host u_host
    (
        .i_link_clk(link_clk), .i_busy(busy), .i_ans_valid(ans_valid),
        .i_ans(ans), .o_req_valid(req_valid), .o_req(req)
    );

    // ======================================================================
    // comparison and access helpers
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic access(input req_kind_t kind, input logic [7:0] addr,
                          input logic [15:0] data, input logic [7:0] tail);
        link_ans_t got;
        logic      ok;
        u_host.do_req(kind, addr, got, ok);
        check("answer present", 24'h000001, {23'h0, ok});
        check("answer", {data, tail}, got);
    endtask

    // fault word expected from a condition vector
    function automatic logic [15:0] fw(input logic [10:0] c);
        return {4'h0, c, 1'b0};
    endfunction

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ======================================================================
    // main sequence; reset spans link edges too, as the bank syncs it over
    initial
    begin
        logic [10:0] c;
        logic [15:0] w;
        repeat (8) @(posedge link_clk);
        @(posedge sys_clk) reset_n <= 1'b1;
        repeat (4) @(posedge link_clk);
        access(REQ_MEM_READ, 8'h0E, UNIT[31:16], 8'h00);
        access(REQ_MEM_READ, 8'h10, UNIT[15:0], 8'h00);
        access(REQ_MEM_READ, 8'h0C, VERSION, 8'h00);
        access(REQ_MEM_READ, 8'h30, 16'h0000, 8'h00);
        access(REQ_SENSOR_DATA, 8'h00, SENSOR, 8'h00);
        // pulsed pattern stays after its cause goes away
        @(posedge sys_clk) fault_cond <= 11'h5A5;
        repeat (2) @(posedge sys_clk);
        fault_cond <= 11'h000;
        repeat (40) @(posedge sys_clk);
        w = fw(11'h5A5);
        check("sticky word", {8'h00, w}, {8'h00, fault_word});
        access(REQ_MEM_READ, 8'h0B, {w[7:0], VERSION[15:8]}, w[7:0]);
        access(REQ_MEM_READ, 8'h0A, 16'h0000, 8'h00);
        // walk each flag through set, re-assert, data clear
        for (int k = 0; k < 11; k++)
        begin
            c = 11'h001 << k;
            w = fw(c);
            @(posedge sys_clk) fault_cond <= c;
            repeat (8) @(posedge sys_clk);
            check("flag position", {8'h00, w}, {8'h00, fault_word});
            access(REQ_MEM_READ, 8'h0A, w, w[7:0]);
            access(REQ_MEM_READ, 8'h0A, w, w[7:0]);
            @(posedge sys_clk) fault_cond <= 11'h000;
            repeat (8) @(posedge sys_clk);
            access(REQ_SENSOR_DATA, 8'h00, SENSOR, w[7:0]);
            access(REQ_MEM_READ, 8'h0A, 16'h0000, 8'h00);
        end
        end_of_test();
    end

    // watchdog well past the expected run of about 26 us
    initial
    begin
        #150000;
        mismatches++;
        end_of_test();
    end
endmodule
